// file: include/gating_pkg.sv
// Shared constants for the peripheral block gating logic
package gating_pkg;

  // Bus widths
  localparam int ADDR_W = 18;    // Byte address width, covers index times four
  localparam int DATA_W = 32;    // APB data width
  localparam int REG_W = 8;      // Every gate register is one byte
  localparam int REG_CNT = 6;    // Number of gate registers
  localparam int SLOT_W = 3;     // Width of a register slot number
  localparam int NUM_PERIPH = 16;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_CONVERTER = 16'hF060;
  localparam logic [15:0] IDX_SMALL_TIMER = 16'hF068;
  localparam logic [15:0] IDX_SERIAL = 16'hF06A;
  localparam logic [15:0] IDX_COMPARATOR = 16'hF06B;
  localparam logic [15:0] IDX_WIDE_TIMER = 16'hF06E;
  localparam logic [15:0] IDX_PWM = 16'hF06F;

  // Slot numbers inside the register array
  localparam logic [SLOT_W-1:0] SLOT_SMALL_TIMER = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_SERIAL = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_COMPARATOR = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_CONVERTER = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_WIDE_TIMER = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_PWM = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_NONE = 3'h7;

  // Writable bit masks; other bits are read-only zero
  localparam logic [REG_W-1:0] MASK_SMALL_TIMER = 8'h03;
  localparam logic [REG_W-1:0] MASK_SERIAL = 8'h8D;
  localparam logic [REG_W-1:0] MASK_COMPARATOR = 8'h40;
  localparam logic [REG_W-1:0] MASK_CONVERTER = 8'h01;
  localparam logic [REG_W-1:0] MASK_WIDE_TIMER = 8'h0F;
  localparam logic [REG_W-1:0] MASK_PWM = 8'h0F;

  // Reset values; every flag starts cleared
  localparam logic [REG_W-1:0] RST_SMALL_TIMER = 8'h00;
  localparam logic [REG_W-1:0] RST_SERIAL = 8'h00;
  localparam logic [REG_W-1:0] RST_COMPARATOR = 8'h00;
  localparam logic [REG_W-1:0] RST_CONVERTER = 8'h00;
  localparam logic [REG_W-1:0] RST_WIDE_TIMER = 8'h00;
  localparam logic [REG_W-1:0] RST_PWM = 8'h00;

  // Flag bit positions inside their registers
  localparam int BIT_TIMER0 = 0;
  localparam int BIT_TIMER1 = 1;
  localparam int BIT_TWOWIRE = 7;
  localparam int BIT_SECOND_UART = 3;
  localparam int BIT_FIRST_UART = 2;
  localparam int BIT_SYNC_SERIAL = 0;
  localparam int BIT_COMPARATOR = 6;
  localparam int BIT_SAR = 0;
  localparam int BIT_TIMER8 = 0;
  localparam int BIT_TIMER9 = 1;
  localparam int BIT_TIMER_A = 2;
  localparam int BIT_TIMER_B = 3;
  localparam int BIT_PWM4 = 0;
  localparam int BIT_PWM5 = 1;
  localparam int BIT_PWM6 = 2;
  localparam int BIT_PWM7 = 3;

  // Positions of each peripheral on the gating output vectors
  localparam int P_TIMER0 = 0;
  localparam int P_TIMER1 = 1;
  localparam int P_TWOWIRE = 2;
  localparam int P_SECOND_UART = 3;
  localparam int P_FIRST_UART = 4;
  localparam int P_SYNC_SERIAL = 5;
  localparam int P_COMPARATOR = 6;
  localparam int P_SAR = 7;
  localparam int P_TIMER8 = 8;
  localparam int P_TIMER9 = 9;
  localparam int P_TIMER_A = 10;
  localparam int P_TIMER_B = 11;
  localparam int P_PWM4 = 12;
  localparam int P_PWM5 = 13;
  localparam int P_PWM6 = 14;
  localparam int P_PWM7 = 15;

  // Byte address of a register from its index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  // Maps a bus address onto a register slot, SLOT_NONE if unmapped
  function automatic logic [SLOT_W-1:0] reg_slot(input logic [ADDR_W-1:0] addr);
    if (addr == byte_addr(IDX_SMALL_TIMER)) begin
      reg_slot = SLOT_SMALL_TIMER;
    end else if (addr == byte_addr(IDX_SERIAL)) begin
      reg_slot = SLOT_SERIAL;
    end else if (addr == byte_addr(IDX_COMPARATOR)) begin
      reg_slot = SLOT_COMPARATOR;
    end else if (addr == byte_addr(IDX_CONVERTER)) begin
      reg_slot = SLOT_CONVERTER;
    end else if (addr == byte_addr(IDX_WIDE_TIMER)) begin
      reg_slot = SLOT_WIDE_TIMER;
    end else if (addr == byte_addr(IDX_PWM)) begin
      reg_slot = SLOT_PWM;
    end else begin
      reg_slot = SLOT_NONE;
    end
  endfunction

endpackage

// file: rtl/gate_byte_reg.sv
// One byte-wide gate register with a fixed writable mask
`timescale 1ns/100ps
`default_nettype none
module gate_byte_reg
  import gating_pkg::*;
#(
  parameter logic [REG_W-1:0] WMASK = 8'hFF,
  parameter logic [REG_W-1:0] RESET_VAL = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [REG_W-1:0] wr_data,
  output logic [REG_W-1:0] value_d,
  output logic [REG_W-1:0] value_q
);

  // Register state
  typedef struct packed {
    logic [REG_W-1:0] value; // Stored flags
  } state_s;

  state_s st_q;
  state_s st_d;

  // Next value: only writable bits take write data, the rest keep their current value
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.value = (wr_data & WMASK) | (st_q.value & ~WMASK);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{value: RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign value_d = st_d.value;
  assign value_q = st_q.value;

endmodule
`default_nettype wire

// file: rtl/periph_gate_cell.sv
// Reset, clock enable and write permit for one gated peripheral
`timescale 1ns/100ps
`default_nettype none
module periph_gate_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic off_d,
  output logic rst_n,
  output logic clk_en,
  output logic wr_allow
);

  // Cell state, all three follow the flag in the same cycle
  typedef struct packed {
    logic rst_n;    // Low holds the peripheral in reset
    logic clk_en;   // Feeds the external clock gate
    logic wr_allow; // Low discards register writes
  } state_s;

  state_s st_q;
  state_s st_d;

  // Fed from the flag's next value so outputs line up with the flag
  always_comb begin
    st_d.rst_n = ~off_d;
    st_d.clk_en = ~off_d;
    st_d.wr_allow = ~off_d;
  end

  // System reset keeps the peripheral in reset but clocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{rst_n: 1'b0, clk_en: 1'b1, wr_allow: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign rst_n = st_q.rst_n;
  assign clk_en = st_q.clk_en;
  assign wr_allow = st_q.wr_allow;

endmodule
`default_nettype wire

// file: rtl/peripheral_block_gating.sv
// APB register block that gates reset, clock and writes of peripherals
`timescale 1ns/100ps
`default_nettype none
module peripheral_block_gating
  import gating_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_PERIPH-1:0] periph_rst_n,
  output logic [NUM_PERIPH-1:0] periph_clk_en,
  output logic [NUM_PERIPH-1:0] periph_wr_allow
);

  // Bus slave state
  typedef struct packed {
    logic pready;              // High during the single access cycle
    logic pslverr;             // Unmapped address flagged in access cycle
    logic [DATA_W-1:0] prdata; // Read data captured in setup cycle
    logic [SLOT_W-1:0] slot;   // Decoded register of the transfer
  } state_s;

  state_s st_q;
  state_s st_d;

  // Register values, current and next
  logic [REG_CNT-1:0][REG_W-1:0] reg_q;
  logic [REG_CNT-1:0][REG_W-1:0] reg_d;
  logic [REG_CNT-1:0] reg_wr;    // Write strobe per register
  logic wr_accept;               // Write completing in this cycle
  logic [SLOT_W-1:0] setup_slot; // Slot decoded from the live address

  // Named disable flags, next values feed the gate cells
  logic timer0_off;
  logic timer1_off;
  logic twowire_off;
  logic second_uart_off;
  logic first_uart_off;
  logic sync_serial_off;
  logic comparator_off;
  logic sar_converter_off;
  logic timer8_off;
  logic timer9_off;
  logic timer_a_off;
  logic timer_b_off;
  logic pwm_ch4_off;
  logic pwm_ch5_off;
  logic pwm_ch6_off;
  logic pwm_ch7_off;
  logic [NUM_PERIPH-1:0] off_d;  // Flag vector, next value
  logic [NUM_PERIPH-1:0] off_q;  // Flag vector, current value

  // Setup-cycle decode
  assign setup_slot = reg_slot(paddr);

  // Write takes effect only at the completing access edge, low byte lane
  assign wr_accept = psel & penable & st_q.pready & pwrite & ~st_q.pslverr
                     & pstrb[0];

  // Per-register write strobes
  always_comb begin
    for (int i = 0; i < REG_CNT; i++) begin
      reg_wr[i] = wr_accept && (st_q.slot == SLOT_W'(i));
    end
  end

  // APB slave: answer in the first access cycle, no wait states
  always_comb begin
    st_d = st_q;
    if (psel && !penable) begin
      // Setup cycle: decode and capture read data
      st_d.pready = 1'b1;
      st_d.slot = setup_slot;
      st_d.pslverr = (setup_slot == SLOT_NONE);
      if (setup_slot == SLOT_NONE) begin
        st_d.prdata = '0;
      end else begin
        // Byte in the low lane, upper bits read zero
        st_d.prdata = {{(DATA_W-REG_W){1'b0}}, reg_q[setup_slot]};
      end
    end else begin
      // Access done or idle
      st_d.pready = 1'b0;
      st_d.pslverr = 1'b0;
      st_d.prdata = '0;
      st_d.slot = SLOT_NONE;
    end
  end

  // Bus state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{pready: 1'b0, pslverr: 1'b0, prdata: '0, slot: SLOT_NONE};
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;

  // Gate registers; masks keep unassigned bits zero
  gate_byte_reg #(.WMASK(MASK_SMALL_TIMER), .RESET_VAL(RST_SMALL_TIMER)) u_small_timer (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(reg_wr[SLOT_SMALL_TIMER]),
    .wr_data(pwdata[REG_W-1:0]),
    .value_d(reg_d[SLOT_SMALL_TIMER]),
    .value_q(reg_q[SLOT_SMALL_TIMER])
  );

  gate_byte_reg #(.WMASK(MASK_SERIAL), .RESET_VAL(RST_SERIAL)) u_serial (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(reg_wr[SLOT_SERIAL]),
    .wr_data(pwdata[REG_W-1:0]),
    .value_d(reg_d[SLOT_SERIAL]),
    .value_q(reg_q[SLOT_SERIAL])
  );

  gate_byte_reg #(.WMASK(MASK_COMPARATOR), .RESET_VAL(RST_COMPARATOR)) u_comparator (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(reg_wr[SLOT_COMPARATOR]),
    .wr_data(pwdata[REG_W-1:0]),
    .value_d(reg_d[SLOT_COMPARATOR]),
    .value_q(reg_q[SLOT_COMPARATOR])
  );

  gate_byte_reg #(.WMASK(MASK_CONVERTER), .RESET_VAL(RST_CONVERTER)) u_converter (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(reg_wr[SLOT_CONVERTER]),
    .wr_data(pwdata[REG_W-1:0]),
    .value_d(reg_d[SLOT_CONVERTER]),
    .value_q(reg_q[SLOT_CONVERTER])
  );

  gate_byte_reg #(.WMASK(MASK_WIDE_TIMER), .RESET_VAL(RST_WIDE_TIMER)) u_wide_timer (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(reg_wr[SLOT_WIDE_TIMER]),
    .wr_data(pwdata[REG_W-1:0]),
    .value_d(reg_d[SLOT_WIDE_TIMER]),
    .value_q(reg_q[SLOT_WIDE_TIMER])
  );

  gate_byte_reg #(.WMASK(MASK_PWM), .RESET_VAL(RST_PWM)) u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(reg_wr[SLOT_PWM]),
    .wr_data(pwdata[REG_W-1:0]),
    .value_d(reg_d[SLOT_PWM]),
    .value_q(reg_q[SLOT_PWM])
  );

  // Flag extraction from the next register values
  assign timer0_off = reg_d[SLOT_SMALL_TIMER][BIT_TIMER0];
  assign timer1_off = reg_d[SLOT_SMALL_TIMER][BIT_TIMER1];
  assign twowire_off = reg_d[SLOT_SERIAL][BIT_TWOWIRE];
  assign second_uart_off = reg_d[SLOT_SERIAL][BIT_SECOND_UART];
  assign first_uart_off = reg_d[SLOT_SERIAL][BIT_FIRST_UART];
  assign sync_serial_off = reg_d[SLOT_SERIAL][BIT_SYNC_SERIAL];
  assign comparator_off = reg_d[SLOT_COMPARATOR][BIT_COMPARATOR];
  assign sar_converter_off = reg_d[SLOT_CONVERTER][BIT_SAR];
  assign timer8_off = reg_d[SLOT_WIDE_TIMER][BIT_TIMER8];
  assign timer9_off = reg_d[SLOT_WIDE_TIMER][BIT_TIMER9];
  assign timer_a_off = reg_d[SLOT_WIDE_TIMER][BIT_TIMER_A];
  assign timer_b_off = reg_d[SLOT_WIDE_TIMER][BIT_TIMER_B];
  assign pwm_ch4_off = reg_d[SLOT_PWM][BIT_PWM4];
  assign pwm_ch5_off = reg_d[SLOT_PWM][BIT_PWM5];
  assign pwm_ch6_off = reg_d[SLOT_PWM][BIT_PWM6];
  assign pwm_ch7_off = reg_d[SLOT_PWM][BIT_PWM7];

  // Flag vector in output order
  always_comb begin
    off_d[P_TIMER0] = timer0_off;
    off_d[P_TIMER1] = timer1_off;
    off_d[P_TWOWIRE] = twowire_off;
    off_d[P_SECOND_UART] = second_uart_off;
    off_d[P_FIRST_UART] = first_uart_off;
    off_d[P_SYNC_SERIAL] = sync_serial_off;
    off_d[P_COMPARATOR] = comparator_off;
    off_d[P_SAR] = sar_converter_off;
    off_d[P_TIMER8] = timer8_off;
    off_d[P_TIMER9] = timer9_off;
    off_d[P_TIMER_A] = timer_a_off;
    off_d[P_TIMER_B] = timer_b_off;
    off_d[P_PWM4] = pwm_ch4_off;
    off_d[P_PWM5] = pwm_ch5_off;
    off_d[P_PWM6] = pwm_ch6_off;
    off_d[P_PWM7] = pwm_ch7_off;
  end

  // Current flag vector, same mapping from the stored values
  always_comb begin
    off_q[P_TIMER0] = reg_q[SLOT_SMALL_TIMER][BIT_TIMER0];
    off_q[P_TIMER1] = reg_q[SLOT_SMALL_TIMER][BIT_TIMER1];
    off_q[P_TWOWIRE] = reg_q[SLOT_SERIAL][BIT_TWOWIRE];
    off_q[P_SECOND_UART] = reg_q[SLOT_SERIAL][BIT_SECOND_UART];
    off_q[P_FIRST_UART] = reg_q[SLOT_SERIAL][BIT_FIRST_UART];
    off_q[P_SYNC_SERIAL] = reg_q[SLOT_SERIAL][BIT_SYNC_SERIAL];
    off_q[P_COMPARATOR] = reg_q[SLOT_COMPARATOR][BIT_COMPARATOR];
    off_q[P_SAR] = reg_q[SLOT_CONVERTER][BIT_SAR];
    off_q[P_TIMER8] = reg_q[SLOT_WIDE_TIMER][BIT_TIMER8];
    off_q[P_TIMER9] = reg_q[SLOT_WIDE_TIMER][BIT_TIMER9];
    off_q[P_TIMER_A] = reg_q[SLOT_WIDE_TIMER][BIT_TIMER_A];
    off_q[P_TIMER_B] = reg_q[SLOT_WIDE_TIMER][BIT_TIMER_B];
    off_q[P_PWM4] = reg_q[SLOT_PWM][BIT_PWM4];
    off_q[P_PWM5] = reg_q[SLOT_PWM][BIT_PWM5];
    off_q[P_PWM6] = reg_q[SLOT_PWM][BIT_PWM6];
    off_q[P_PWM7] = reg_q[SLOT_PWM][BIT_PWM7];
  end

  // One gate cell per peripheral: reset hold, clock stop, write block
  for (genvar g = 0; g < NUM_PERIPH; g++) begin : g_cell
    periph_gate_cell u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .off_d(off_d[g]),
      .rst_n(periph_rst_n[g]),
      .clk_en(periph_clk_en[g]),
      .wr_allow(periph_wr_allow[g])
    );
  end

  // Helper: high from the second edge after reset release onward
  logic out_of_reset_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_of_reset_q <= 1'b0;
    end else begin
      out_of_reset_q <= 1'b1;
    end
  end

  // Disabled peripheral is held in reset
  property p_held_in_reset;
    @(posedge pclk) disable iff (!presetn)
      out_of_reset_q |-> ((periph_rst_n & off_q) == '0);
  endproperty
  a_held_in_reset: assert property (p_held_in_reset)
    else $error("Disabled peripheral not held in reset");

  // Disabled peripheral has its clock stopped
  property p_clock_stopped;
    @(posedge pclk) disable iff (!presetn)
      (periph_clk_en & off_q) == '0;
  endproperty
  a_clock_stopped: assert property (p_clock_stopped)
    else $error("Disabled peripheral still clocked");

  // Writes to a disabled peripheral are blocked
  property p_write_blocked;
    @(posedge pclk) disable iff (!presetn)
      (periph_wr_allow & off_q) == '0;
  endproperty
  a_write_blocked: assert property (p_write_blocked)
    else $error("Write permit open on disabled peripheral");

  // Clearing the timer 0 flag releases it on the same edge
  property p_release_timer0;
    @(posedge pclk) disable iff (!presetn)
      $fell(off_q[P_TIMER0]) |->
        periph_rst_n[P_TIMER0] && periph_clk_en[P_TIMER0] && periph_wr_allow[P_TIMER0];
  endproperty
  a_release_timer0: assert property (p_release_timer0)
    else $error("Timer 0 not released after flag cleared");

  // Flags are zero on the first edge after reset release
  property p_flags_clear_at_reset;
    @(posedge pclk) disable iff (!presetn)
      !out_of_reset_q |-> (off_q == '0);
  endproperty
  a_flags_clear_at_reset: assert property (p_flags_clear_at_reset)
    else $error("Disable flag set right after reset");

  // A small timer write lands on timer 0 and 1 flags next cycle
  property p_small_timer_map;
    @(posedge pclk) disable iff (!presetn)
      reg_wr[SLOT_SMALL_TIMER] |=> (off_q[P_TIMER0] == $past(pwdata[BIT_TIMER0]))
        && (off_q[P_TIMER1] == $past(pwdata[BIT_TIMER1]));
  endproperty
  a_small_timer_map: assert property (p_small_timer_map)
    else $error("Small timer flags do not follow write");

  // Serial register write lands on its four flags
  property p_serial_map;
    @(posedge pclk) disable iff (!presetn)
      reg_wr[SLOT_SERIAL] |=>
        ({off_q[P_TWOWIRE], off_q[P_SECOND_UART], off_q[P_FIRST_UART], off_q[P_SYNC_SERIAL]}
          == {$past(pwdata[7]), $past(pwdata[3]), $past(pwdata[2]), $past(pwdata[0])});
  endproperty
  a_serial_map: assert property (p_serial_map)
    else $error("Serial flags do not follow write");

  // Unassigned bits always read back zero
  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      ((reg_q[SLOT_SMALL_TIMER] & ~MASK_SMALL_TIMER) == '0)
      && ((reg_q[SLOT_SERIAL] & ~MASK_SERIAL) == '0)
      && ((reg_q[SLOT_COMPARATOR] & ~MASK_COMPARATOR) == '0)
      && ((reg_q[SLOT_CONVERTER] & ~MASK_CONVERTER) == '0)
      && ((reg_q[SLOT_WIDE_TIMER] & ~MASK_WIDE_TIMER) == '0)
      && ((reg_q[SLOT_PWM] & ~MASK_PWM) == '0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Unassigned register bit is set");

  // Wide timer, converter and PWM writes map to their flags
  property p_wide_pwm_map;
    @(posedge pclk) disable iff (!presetn)
      (reg_wr[SLOT_WIDE_TIMER] || reg_wr[SLOT_PWM] || reg_wr[SLOT_CONVERTER]) |=>
        (!$past(reg_wr[SLOT_WIDE_TIMER])
          || (off_q[P_TIMER_B:P_TIMER8] == $past(pwdata[3:0])))
        && (!$past(reg_wr[SLOT_PWM]) || (off_q[P_PWM7:P_PWM4] == $past(pwdata[3:0])))
        && (!$past(reg_wr[SLOT_CONVERTER]) || (off_q[P_SAR] == $past(pwdata[BIT_SAR])));
  endproperty
  a_wide_pwm_map: assert property (p_wide_pwm_map)
    else $error("Wide timer, converter or PWM flags mismatch");

  // Setup cycle is answered with pready in the next cycle, byte read data
  property p_one_cycle_answer;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready && (prdata[DATA_W-1:REG_W] == '0);
  endproperty
  a_one_cycle_answer: assert property (p_one_cycle_answer)
    else $error("APB answer late or upper read bits set");

endmodule
`default_nettype wire

// file: dv/periph_model.sv
// Behavioural bank of gated peripherals, one data byte each
`timescale 1ns/100ps
`default_nettype none
module periph_model (
  input wire logic pclk,
  input wire logic [15:0] rst_n,
  input wire logic [15:0] clk_en,
  input wire logic [15:0] wr_allow,
  input wire logic wr_stb,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_val,
  output logic [127:0] regs
);
  logic [7:0] mem [16]; // One byte per peripheral
  for (genvar i = 0; i < 16; i++) begin : g_p
    // Cleared in reset, written only while clocked and permitted
    always_ff @(posedge pclk or negedge rst_n[i]) begin
      if (!rst_n[i]) begin
        mem[i] <= 8'h00;
      end else if (clk_en[i] && wr_allow[i] && wr_stb && wr_idx == 4'(i)) begin
        mem[i] <= wr_val;
      end
    end
    assign regs[8*i +: 8] = mem[i];
  end
endmodule
`default_nettype wire

// file: dv/peripheral_block_gating_bench.sv
// Self-checking bench for the peripheral block gating registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module peripheral_block_gating_bench
  import gating_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stb = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd, d;
  logic [3:0] pstrb = 4'hF, idx = 4'h0;
  logic pready, pslverr, err;
  logic [NUM_PERIPH-1:0] rst_n, clk_en, wr_allow;
  logic [7:0] val = 8'h00, v;
  logic [127:0] regs;
  logic [7:0] sh [6]; // Shadow of the six registers
  int seed = 32'hD902;
  int bad_count = 0;
  int total_checks = 0;
  int j;
  localparam logic [15:0] IDX [6] = '{IDX_SMALL_TIMER, IDX_SERIAL, IDX_COMPARATOR,
    IDX_CONVERTER, IDX_WIDE_TIMER, IDX_PWM};
  localparam logic [7:0] MSK [6] = '{8'h03, 8'h8D, 8'h40, 8'h01, 8'h0F, 8'h0F};
  // Register and bit of each peripheral flag
  localparam int FS [16] = '{0, 0, 1, 1, 1, 1, 2, 3, 4, 4, 4, 4, 5, 5, 5, 5};
  localparam int FB [16] = '{0, 1, 7, 3, 2, 0, 6, 0, 0, 1, 2, 3, 0, 1, 2, 3};
  peripheral_block_gating dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_rst_n(rst_n),
    .periph_clk_en(clk_en), .periph_wr_allow(wr_allow));
  periph_model model_u (.pclk(pclk), .rst_n(rst_n), .clk_en(clk_en), .wr_allow(wr_allow),
    .wr_stb(stb), .wr_idx(idx), .wr_val(val), .regs(regs));
  // Clock, 20 ns period
  initial begin
    forever #10 pclk = ~pclk;
  end
  // Expected disable flags from the shadow
  function automatic logic [15:0] flags();
    logic [15:0] f;
    for (int p = 0; p < 16; p++) f[p] = sh[FS[p]][FB[p]];
    return f;
  endfunction
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] dd,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= dd; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Gate outputs against shadow flags
  task automatic outs();
    @(negedge pclk);
    `CHK("rst_n", ~flags(), rst_n)
    `CHK("clk_en", ~flags(), clk_en)
    `CHK("wr_allow", ~flags(), wr_allow)
  endtask
  // Register write, shadow kept when lane 0 strobed
  task automatic wreg(input int r, input logic [31:0] dd, input logic [3:0] s);
    apb(1'b1, {IDX[r], 2'b00}, dd, s);
    if (s[0]) sh[r] = dd[7:0] & MSK[r];
    outs();
  endtask
  // Read back all registers
  task automatic rall();
    for (int r = 0; r < 6; r++) begin
      apb(1'b0, {IDX[r], 2'b00}, 32'h0, 4'hF);
      `CHK("reg", {24'h0, sh[r]}, rd)
      `CHK("err", 1'b0, err)
    end
  endtask
  // Write into one peripheral's register
  task automatic pw(input int p, input logic [7:0] x);
    @(posedge pclk);
    stb <= 1'b1; idx <= 4'(p); val <= x;
    @(posedge pclk);
    stb <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude();
  end
  // Main sequence
  initial begin
    foreach (sh[r]) sh[r] = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rall();
    outs();
    $display("test reset done");
    for (int p = 0; p < 16; p++) begin
      v = 8'($unsigned($random(seed))) | 8'h01;
      wreg(FS[p], 32'h1 << FB[p], 4'h1);
      pw(p, v);
      `CHK("blocked", 8'h00, regs[8*p +: 8])
      wreg(FS[p], 32'h0, 4'h1);
      pw(p, v);
      `CHK("written", v, regs[8*p +: 8])
      wreg(FS[p], 32'h1 << FB[p], 4'h1);
      `CHK("reset", 8'h00, regs[8*p +: 8])
      wreg(FS[p], 32'h0, 4'h1);
    end
    $display("test per flag done");
    apb(1'b1, 18'h3C184, 32'hFF, 4'hF);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b0, 18'h3C184, 32'h0, 4'hF);
    `CHK("unmapped data", 32'h0, rd)
    $display("test unmapped done");
    repeat (60) begin
      j = $unsigned($random(seed)) % 6;
      d = $random(seed);
      wreg(j, d, 4'($random(seed)));
    end
    wreg(2, 32'hFFFF_FFBF, 4'hF);
    rall();
    $display("test random done");
    // Reset in mid-run with flags left set clears them all
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    `CHK("rst_n in reset", 16'h0000, rst_n)
    `CHK("clk_en in reset", 16'hFFFF, clk_en)
    `CHK("wr_allow in reset", 16'h0000, wr_allow)
    `CHK("model cleared", 128'h0, regs)
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (sh[r]) sh[r] = 8'h00;
    rall();
    outs();
    $display("test mid reset done");
    conclude();
  end
endmodule
`default_nettype wire
